// >>> iec_pkg.sv
// Function
// - Mode 000 interval, mode 001 event count.
// - Interval start clears, toggles, loads shadow from compare.
// - Interval match clears, toggles, raises cycle match.
// - Interval equals compare plus one ticks.
// - Second compare also shadowed and matched.
// - Compare zero keeps count zero, matches each tick.
// - Compare FFFFH wraps without any wrap event.
// - Cycle compare write reaches shadow immediately.
// - Lowered compare runs through FFFFH first.
// - Lower second compare toggles output b per cycle.
// - Higher second compare never matches.
// - Event mode counts input edges, output a idle.
// - Event start clears count and loads shadow.
// - Event match clears count, raises cycle match.
// - Read-back returns live count while running.
// - Read-back reads zero while stopped.
// - External count clock only from event_in_a.
//
// Package for the interval and event counter: register map, fields,
// reset values and the control word carrier. Assumes an APB master.
package iec_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] IEC_CTRL_OFF = 8'h00;
	localparam logic [7:0] IEC_CMP0_OFF = 8'h04;
	localparam logic [7:0] IEC_CMP1_OFF = 8'h08;
	localparam logic [7:0] IEC_CNT_OFF = 8'h0c;
	localparam logic [7:0] IEC_STAT_OFF = 8'h10;
	localparam logic [7:0] IEC_DIV_OFF = 8'h14;

	// Counter values that mark the stopped and cleared states.
	localparam logic [15:0] IEC_CNT_IDLE = 16'hffff;
	localparam logic [15:0] IEC_CNT_ZERO = 16'h0000;

	// Reset values of the writable registers.
	localparam logic [15:0] IEC_CMP_RST = 16'h0000;
	localparam logic [15:0] IEC_DIV_RST = 16'h0000;
	localparam logic [11:0] IEC_CTRL_RST = 12'h000;

	// Status bit positions (write one to clear).
	localparam int IEC_ST_CYC = 0;
	localparam int IEC_ST_SEC = 1;

	// Operating modes held in the three-bit mode field.
	typedef enum logic [2:0] {
		IEC_MODE_INTERVAL = 3'b000,
		IEC_MODE_EVENT = 3'b001
	} iec_mode_t;

	// Edge selections for the event input.
	localparam logic [1:0] IEC_EDGE_NONE = 2'b00;
	localparam logic [1:0] IEC_EDGE_RISE = 2'b01;
	localparam logic [1:0] IEC_EDGE_FALL = 2'b10;
	localparam logic [1:0] IEC_EDGE_BOTH = 2'b11;

	// Control word, bit 0 upward: run, mode, clock source, capture edge,
	// event edge, output enables, second match mask.
	typedef struct packed {
		logic second_match_mask;  // Bit 11.
		logic wave_b_en;          // Bit 10.
		logic wave_a_en;          // Bit 9.
		logic [1:0] event_edge;   // Bits 8:7.
		logic edge_select_hi;     // Bit 6.
		logic edge_select_lo;     // Bit 5.
		logic event_clock_select; // Bit 4.
		logic [2:0] mode_select;  // Bits 3:1.
		logic timer_run_bit;      // Bit 0.
	} iec_ctrl_t;

endpackage

// >>> iec_timer_unit.sv
// Interval and event counter: 16-bit up-counter, two compare channels
// with shadow buffers, square wave outputs and an APB register slave.
// Assumes pclk at 100 MHz and event_in_a synchronous to pclk.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module iec_timer_unit
	import iec_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic event_in_a,
	output logic wave_out_a,
	output logic wave_out_b,
	output logic cycle_match_irq,
	output logic second_match_irq
);

	////////////////////////////////////////////////////////////////////////
	// Registers and internal state.

	iec_ctrl_t ctrl_reg;              // Control word.
	logic [15:0] cycle_compare_reg;   // Compare register 0.
	logic [15:0] second_compare_reg;  // Compare register 1.
	logic [15:0] cycle_compare_shadow;
	logic [15:0] second_compare_shadow;
	logic [15:0] div_reg;             // Internal count clock divider.
	logic [15:0] presc_reg;           // Divider counter.
	logic [CNT_W-1:0] cnt_reg;        // The counter itself.
	logic started_reg;                // First count tick seen, or first run cycle in event mode.
	logic run_d_reg;                  // Run state delayed, for count read-back.
	logic event_d_reg;                // Event input delayed a cycle.
	logic [1:0] status_reg;           // Sticky match flags.
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic wave_a_reg;
	logic wave_b_reg;
	logic cyc_irq_reg;
	logic sec_irq_reg;

	// Decoded bus strobes and counting conditions.
	logic access;
	logic wr_en;
	logic mapped;
	logic mode_ok;
	logic running;
	logic edge_ok;
	logic presc_tick;
	logic tick;
	logic start_tick;
	logic cyc_match;
	logic sec_match;
	logic ctrl_wr;
	logic cmp0_wr;
	logic cmp1_wr;
	logic stat_wr;

	////////////////////////////////////////////////////////////////////////
	// Bus decode.

	// The access phase completes at the edge where pready is high.
	assign access = psel & penable & pready_reg;
	assign wr_en = access & pwrite;
	assign mapped = (paddr == IEC_CTRL_OFF) || (paddr == IEC_CMP0_OFF) ||
		(paddr == IEC_CMP1_OFF) || (paddr == IEC_CNT_OFF) ||
		(paddr == IEC_STAT_OFF) || (paddr == IEC_DIV_OFF);
	assign ctrl_wr = wr_en && (paddr == IEC_CTRL_OFF);
	assign cmp0_wr = wr_en && (paddr == IEC_CMP0_OFF);
	assign cmp1_wr = wr_en && (paddr == IEC_CMP1_OFF);
	assign stat_wr = wr_en && (paddr == IEC_STAT_OFF);

	////////////////////////////////////////////////////////////////////////
	// Count clock selection.

	// Only the two implemented modes run; other codes leave it stopped.
	assign mode_ok = (ctrl_reg.mode_select == IEC_MODE_INTERVAL) ||
		(ctrl_reg.mode_select == IEC_MODE_EVENT);
	assign running = ctrl_reg.timer_run_bit && mode_ok;

	// Valid edge of the event pin, the only external count source.
	always_comb begin
		unique case (ctrl_reg.event_edge)
			IEC_EDGE_RISE: edge_ok = event_in_a & ~event_d_reg;
			IEC_EDGE_FALL: edge_ok = ~event_in_a & event_d_reg;
			IEC_EDGE_BOTH: edge_ok = event_in_a ^ event_d_reg;
			default: edge_ok = 1'b0;
		endcase
	end

	assign presc_tick = (presc_reg == div_reg);

	// Event mode always counts edges; interval mode counts edges only
	// when the external clock source is chosen.
	always_comb begin
		if (!running) begin
			tick = 1'b0;
		end else if (ctrl_reg.mode_select == IEC_MODE_EVENT) begin
			tick = edge_ok;
		end else if (ctrl_reg.event_clock_select) begin
			tick = edge_ok;
		end else begin
			tick = presc_tick;
		end
	end

	// Interval mode clears FFFFH to zero on the first count tick; event
	// mode clears on the first pclk after run is set, so the first
	// interrupt also takes compare plus one edges. An edge arriving in
	// that very cycle is not counted.
	assign start_tick = !started_reg && (tick || (running &&
		(ctrl_reg.mode_select == IEC_MODE_EVENT)));
	// A match needs the counter already started, so FFFFH on the idle
	// counter never counts as a match against a compare of FFFFH.
	assign cyc_match = tick && started_reg &&
		(cnt_reg == cycle_compare_shadow);
	assign sec_match = tick && started_reg &&
		(cnt_reg == second_compare_shadow);

	////////////////////////////////////////////////////////////////////////
	// Input history and divider.

	// Delayed event input for edge detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_d_reg <= 1'b0;
		end else begin
			event_d_reg <= event_in_a;
		end
	end

	// Divider restarts whenever the timer is stopped, so the first
	// count tick comes a full divided period after start.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_reg <= IEC_DIV_RST;
		end else if (!running || presc_tick) begin
			presc_reg <= IEC_DIV_RST;
		end else begin
			presc_reg <= presc_reg + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers.

	// Control word and divider.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= iec_ctrl_t'(IEC_CTRL_RST);
			div_reg <= IEC_DIV_RST;
		end else begin
			if (ctrl_wr) begin
				ctrl_reg <= iec_ctrl_t'(pwdata[11:0]);
			end
			if (wr_en && (paddr == IEC_DIV_OFF)) begin
				div_reg <= pwdata[15:0];
			end
		end
	end

	// Compare registers; every write lands at once in the shadow too.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_compare_reg <= IEC_CMP_RST;
			second_compare_reg <= IEC_CMP_RST;
		end else begin
			if (cmp0_wr) begin
				cycle_compare_reg <= pwdata[15:0];
			end
			if (cmp1_wr) begin
				second_compare_reg <= pwdata[15:0];
			end
		end
	end

	// Shadows follow writes immediately and are reloaded on start.
	// A lowered compare below the count is therefore missed until the
	// counter has wrapped through FFFFH; software should stop first.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_compare_shadow <= IEC_CMP_RST;
			second_compare_shadow <= IEC_CMP_RST;
		end else begin
			if (cmp0_wr) begin
				cycle_compare_shadow <= pwdata[15:0];
			end else if (start_tick) begin
				cycle_compare_shadow <= cycle_compare_reg;
			end
			if (cmp1_wr) begin
				second_compare_shadow <= pwdata[15:0];
			end else if (start_tick) begin
				second_compare_shadow <= second_compare_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter.

	// Stopped: held at FFFFH. Start clears to zero, a match clears
	// to zero, otherwise count up and wrap naturally past FFFFH. The
	// wrap raises no flag of its own in these modes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= IEC_CNT_IDLE;
			started_reg <= 1'b0;
		end else if (!running) begin
			cnt_reg <= IEC_CNT_IDLE;
			started_reg <= 1'b0;
		end else if (start_tick) begin
			cnt_reg <= IEC_CNT_ZERO;
			started_reg <= 1'b1;
		end else if (cyc_match) begin
			cnt_reg <= IEC_CNT_ZERO;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	// Run bit history; kept for read-back of the start state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_d_reg <= 1'b0;
		end else begin
			run_d_reg <= running;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wave outputs and match events.

	// Output a toggles on start and on cycle match in interval mode only;
	// output b toggles on second match in interval mode only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_a_reg <= 1'b0;
			wave_b_reg <= 1'b0;
		end else if (ctrl_reg.mode_select == IEC_MODE_INTERVAL) begin
			if (ctrl_reg.wave_a_en && (start_tick || cyc_match)) begin
				wave_a_reg <= ~wave_a_reg;
			end
			if (ctrl_reg.wave_b_en && sec_match) begin
				wave_b_reg <= ~wave_b_reg;
			end
		end
	end

	// Request pulses, one cycle per match; the second is gated by its mask.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_irq_reg <= 1'b0;
			sec_irq_reg <= 1'b0;
		end else begin
			cyc_irq_reg <= cyc_match;
			sec_irq_reg <= sec_match && !ctrl_reg.second_match_mask;
		end
	end

	// Sticky flags: a new match wins over a write-one clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= 2'b00;
		end else begin
			status_reg[IEC_ST_CYC] <= cyc_match ||
				(status_reg[IEC_ST_CYC] &&
				!(stat_wr && pwdata[IEC_ST_CYC]));
			status_reg[IEC_ST_SEC] <= sec_match ||
				(status_reg[IEC_ST_SEC] &&
				!(stat_wr && pwdata[IEC_ST_SEC]));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB answer.

	// No wait state: pready rises for the first access cycle, and read
	// data are captured in the same edge so they stand with pready.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= psel && !penable;
			pslverr_reg <= psel && !penable && !mapped;
			prdata_reg <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					IEC_CTRL_OFF: prdata_reg <= {20'h00000, ctrl_reg};
					IEC_CMP0_OFF: prdata_reg <= {16'h0000, cycle_compare_reg};
					IEC_CMP1_OFF: prdata_reg <= {16'h0000, second_compare_reg};
					// Live count while running, zero while stopped.
					IEC_CNT_OFF: prdata_reg <= {16'h0000,
						run_d_reg ? cnt_reg : IEC_CNT_ZERO};
					IEC_STAT_OFF: prdata_reg <= {30'h00000000, status_reg};
					IEC_DIV_OFF: prdata_reg <= {16'h0000, div_reg};
					default: prdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign wave_out_a = wave_a_reg;
	assign wave_out_b = wave_b_reg;
	assign cycle_match_irq = cyc_irq_reg;
	assign second_match_irq = sec_irq_reg;

endmodule

`default_nettype wire

// >>> iec_checker.sv
// Checker for the counter block: APB answer timing and pulse shapes.
// Assumes a bind from the bench top onto the design's ports.
`timescale 1ns/1ns
`default_nettype none
module iec_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic event_in_a,
	input wire logic wave_out_a,
	input wire logic wave_out_b,
	input wire logic cycle_match_irq,
	input wire logic second_match_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	// The slave answers in the first access cycle, for one cycle only.
	ready_in_time_a: assert property (psel && !penable |=> pready)
		else $error("pready did not follow setup");
	ready_single_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	// An error is only flagged together with the answer.
	error_with_ready_a: assert property (pslverr |-> pready && psel)
		else $error("pslverr without pready");
	// Holes in the map read as zero; no register is wider than 16 bits.
	hole_reads_zero_a: assert property (pready && !pwrite &&
		paddr > 8'h14 |-> prdata == 32'h0 && pslverr)
		else $error("unmapped read not refused");
	upper_bits_zero_a: assert property (pready && !pwrite |->
		prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	// Match requests are single-cycle pulses.
	cycle_pulse_a: assert property (cycle_match_irq |=> !cycle_match_irq)
		else $error("cycle match pulse too long");
	second_pulse_a: assert property ($rose(second_match_irq) |=>
		!second_match_irq) else $error("second match pulse too long");
	// Waves leave reset low; nothing can toggle them before a start.
	quiet_reset_a: assert property ($rose(presetn) |->
		(!wave_out_a && !wave_out_b) [*2])
		else $error("waves not low after reset");
endmodule
`default_nettype wire

// >>> iec_event_src.sv
// Partner model: the external event source feeding event_in_a.
// Assumes pclk from the bench; edges are spaced two cycles apart.
`timescale 1ns/1ns
`default_nettype none
module iec_event_src (
	input wire logic pclk,
	output logic event_in_a
);
	// The line idles low until a burst of edges is asked for.
	initial event_in_a = 1'b0;
	// One rising edge per unit; spacing keeps each change distinct.
	task automatic send(input int n);
		repeat (n) begin
			repeat (2) @(posedge pclk);
			event_in_a <= 1'b1;
			repeat (2) @(posedge pclk);
			event_in_a <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> iec_timer_unit_tb_top.sv
// Bench for the counter block: APB tasks plus windowed pulse counts.
// Assumes the divider stays at zero, one tick per pclk, except in the
// zero compare test, which sets it to one.
`timescale 1ns/1ns
`default_nettype none
module iec_timer_unit_tb_top;
	import iec_pkg::*;
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, ev, wa, wb, ci, si, e, wa_q, wb_q;
	int bad_count, n_compared, nc, ns, na, nb, c0, s0, a0, b0;
	iec_timer_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_in_a(ev), .wave_out_a(wa),
		.wave_out_b(wb), .cycle_match_irq(ci), .second_match_irq(si));
	iec_event_src src (.pclk(pclk), .event_in_a(ev));
	////////////////////////////////////////////////////////////////////////
	// Clock at 100 MHz.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Pulse and toggle tallies, updated late so reads see settled values.
	always @(posedge pclk) begin
		wa_q <= wa;
		wb_q <= wb;
		nc <= nc + (ci === 1'b1);
		ns <= ns + (si === 1'b1);
		na <= na + (wa !== wa_q);
		nb <= nb + (wb !== wb_q);
	end
	// One APB transfer; waits for pready, only the watchdog ends a hang.
	// One idle edge follows, so psel is never driven twice in a step.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input string s, input logic [31:0] x,
		input logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", s, x, g);
		end
	endtask
	// Counts over a window of n cycles.
	task automatic win(input int n);
		c0 = nc;
		s0 = ns;
		a0 = na;
		b0 = nb;
		repeat (n) @(posedge pclk);
		c0 = nc - c0;
		s0 = ns - s0;
		a0 = na - a0;
		b0 = nb - b0;
	endtask
	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog: the longest test spans about 66k cycles.
	initial begin
		#900000;
		bad_count++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{nc, ns, na, nb, bad_count, n_compared} = '0;
		{wa_q, wb_q} = '0;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, IEC_CNT_OFF, 0);
		chk("count stopped", 0, q);
		apb(0, 8'h18, 0);
		chk("hole error", 1, e);
		$display("test reset done");
		apb(1, IEC_CMP0_OFF, 4);
		apb(1, IEC_CMP1_OFF, 1);
		apb(1, IEC_CTRL_OFF, 32'h601);
		repeat (3) @(posedge pclk);
		win(20);
		chk("cycle irqs", 4, c0);
		chk("wave a", 4, a0);
		chk("second irqs", 4, s0);
		chk("wave b", 4, b0);
		apb(0, IEC_CNT_OFF, 0);
		chk("live count", 3, q);
		apb(1, IEC_CMP1_OFF, 12);
		apb(1, IEC_CMP0_OFF, 9);
		repeat (12) @(posedge pclk);
		win(20);
		chk("raised period", 2, c0);
		chk("high second", 0, s0);
		chk("wave b still", 0, b0);
		apb(0, IEC_STAT_OFF, 0);
		chk("status flags", 3, q);
		$display("test interval done");
		apb(1, IEC_CTRL_OFF, 0);
		apb(1, IEC_CMP0_OFF, 0);
		// Divider at one keeps each match pulse a single cycle.
		apb(1, IEC_DIV_OFF, 1);
		apb(1, IEC_CTRL_OFF, 32'h201);
		repeat (3) @(posedge pclk);
		win(10);
		chk("zero compare irqs", 5, c0);
		apb(0, IEC_CNT_OFF, 0);
		chk("zero compare count", 0, q);
		apb(1, IEC_CTRL_OFF, 0);
		apb(1, IEC_DIV_OFF, 0);
		repeat (2) @(posedge pclk);
		win(20);
		chk("stopped irqs", 0, c0);
		chk("stopped wave", 0, a0);
		$display("test zero and stop done");
		apb(1, IEC_CMP0_OFF, 20);
		apb(1, IEC_CTRL_OFF, 32'h001);
		repeat (8) @(posedge pclk);
		apb(1, IEC_CMP0_OFF, 3);
		win(65000);
		chk("no early match", 0, c0);
		win(600);
		chk("match after wrap", 1, c0 > 0);
		$display("test lowered compare done");
		apb(1, IEC_CTRL_OFF, 0);
		apb(1, IEC_CMP0_OFF, 2);
		apb(1, IEC_CTRL_OFF, 32'h283);
		c0 = nc;
		a0 = na;
		src.send(3);
		@(posedge pclk);
		chk("first event irq", 1, nc - c0);
		c0 = nc;
		src.send(6);
		@(posedge pclk);
		chk("event irqs", 2, nc - c0);
		chk("event wave a", 0, na - a0);
		$display("test event done");
		end_sim();
	end
endmodule
bind iec_timer_unit iec_checker chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.event_in_a(event_in_a), .wave_out_a(wave_out_a),
	.wave_out_b(wave_out_b), .cycle_match_irq(cycle_match_irq),
	.second_match_irq(second_match_irq));
`default_nettype wire
